// file: verilog/usp_pkg.sv
package usp_pkg;

    localparam int          USP_CHANNELS      = 2;
    localparam int          USP_ADDR_W        = 4;
    localparam int          USP_BUS_W         = 8;
    localparam int          USP_STAT_W        = 7;
    localparam int          USP_UNIT_W        = 4;

    // Output-bus selector codes, bit 0 then bit 1.
    localparam logic [1:0]  USP_SEL_STATUS    = 2'h1;
    localparam logic [1:0]  USP_SEL_UNIT      = 2'h2;
    localparam logic [1:0]  USP_SEL_DIAG      = 2'h3;

    localparam int          USP_VALID_POS     = 7;

    // Replaceable-unit codes.
    localparam logic [3:0]  USP_UNIT_NONE     = 4'h0;
    localparam logic [3:0]  USP_UNIT_CTRL_A   = 4'h1;
    localparam logic [3:0]  USP_UNIT_MODULE_A = 4'h2;
    localparam logic [3:0]  USP_UNIT_POWER    = 4'h3;
    localparam logic [3:0]  USP_UNIT_IO       = 4'h4;
    localparam logic [3:0]  USP_UNIT_CTRL_B   = 4'h5;
    localparam logic [3:0]  USP_UNIT_MODULE_B = 4'h6;

    // Register port offsets.
    localparam logic [3:0]  USP_REG_CTRL      = 4'h0;
    localparam logic [3:0]  USP_REG_STATE     = 4'h1;
    localparam logic [3:0]  USP_REG_IRQ_STAT  = 4'h2;
    localparam logic [3:0]  USP_REG_IRQ_MASK  = 4'h3;
    localparam logic [3:0]  USP_REG_DEVTYPE   = 4'h4;

    // Control register fields.
    localparam int          USP_CTRL_DIS0     = 0;
    localparam int          USP_CTRL_DIS1     = 1;
    localparam logic [7:0]  USP_CTRL_RST      = 8'h00;
    localparam logic [7:0]  USP_DEVTYPE_RST   = 8'h00;
    localparam logic [3:0]  USP_MASK_RST      = 4'h0;

    // Interrupt status bits.
    localparam int          USP_IRQ_SEL0      = 0;
    localparam int          USP_IRQ_SEL1      = 1;
    localparam int          USP_IRQ_PRIO      = 2;
    localparam int          USP_IRQ_REFUSED   = 3;
    localparam int          USP_IRQ_W         = 4;

endpackage : usp_pkg

// file: verilog/usp_unit_mux.sv
`timescale 1ns/1ps
// Builds the input-bus byte for one channel from the selector bits.
module usp_unit_mux (
    input  wire logic                          i_mclk,
    input  wire logic                          i_rst_n,
    input  wire logic                          i_enable,
    input  wire logic [1:0]                    i_selector,
    input  wire logic                          i_tag4,
    input  wire logic                          i_tag5,
    input  wire logic [usp_pkg::USP_STAT_W-1:0] i_op_status,
    input  wire logic                          i_status_valid,
    input  wire logic [usp_pkg::USP_UNIT_W-1:0] i_unit_code,
    input  wire logic                          i_diag_running,
    input  wire logic [usp_pkg::USP_BUS_W-1:0]  i_device_type,
    output logic      [usp_pkg::USP_BUS_W-1:0]  o_bus_in
);
    import usp_pkg::*;

    logic [USP_BUS_W-1:0] bus_d;

    always_comb begin
        bus_d = '0;
        if (i_enable) begin
            if (i_tag4 && i_tag5) begin
                bus_d = i_device_type;
            end else begin
                case (i_selector)
                    USP_SEL_STATUS: begin
                        bus_d = {i_status_valid, i_op_status};
                    end
                    USP_SEL_UNIT: begin
                        // Bits 4..6 held low so a stale status cannot leak out.
                        bus_d = {i_status_valid, 3'h0, i_unit_code};
                    end
                    USP_SEL_DIAG: begin
                        bus_d = {i_diag_running, 7'h00};
                    end
                    default: begin
                        bus_d = '0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_bus_in <= '0;
        end else begin
            o_bus_in <= bus_d;
        end
    end

endmodule : usp_unit_mux

// file: verilog/usp_select_port.sv
`timescale 1ns/1ps
// Contract
// - Selector 10 returns status, bit7 valid.
// - Selector 01 returns replaceable unit code.
// - Unit mode: bits 4-6 unused, bit7 valid.
// - Selector 11: diagnostic running on bit7.
// - Tags 4+5 return device type byte.
// - Commands ignored until selected.
// - Receivers and drivers off while unselected.
// - Own address from 0..15 switches.
// - Compare addresses on select tag.
// - Match needs equal address, cable present.
// - Match drives unit selected response.
// - Match sets connection latch, enables interface.
// - One controller at a time, resolve ties.
// - Reserved: owner selectable, other refused.
// - Release clears reserved condition.
// - Priority select takes over, disables holder.
// - Maintenance disable per channel.
module usp_select_port (
    input  wire logic                            i_mclk,
    input  wire logic                            i_rst_n,
    input  wire logic [3:0]                      i_addr_switch,
    input  wire logic [1:0]                      i_unit_select_tag,
    input  wire logic [7:0]                      i_unit_select_addr,
    input  wire logic [1:0]                      i_cable_absent,
    input  wire logic [1:0]                      i_release,
    input  wire logic [1:0]                      i_priority_select,
    input  wire logic [3:0]                      i_bus_out_sel,
    input  wire logic [1:0]                      i_tag4,
    input  wire logic [1:0]                      i_tag5,
    input  wire logic [usp_pkg::USP_STAT_W-1:0]   i_op_status,
    input  wire logic                            i_status_valid,
    input  wire logic [usp_pkg::USP_UNIT_W-1:0]   i_unit_code,
    input  wire logic                            i_diag_running,
    input  wire logic [3:0]                      i_reg_addr,
    input  wire logic [7:0]                      i_reg_wdata,
    input  wire logic                            i_reg_wr,
    input  wire logic                            i_reg_rd,
    output logic      [7:0]                      o_reg_rdata,
    output logic      [1:0]                      o_unit_selected,
    output logic      [1:0]                      o_iface_enable,
    output logic      [1:0]                      o_reserved,
    output logic      [15:0]                     o_bus_in,
    output logic                                 o_irq
);
    import usp_pkg::*;

    logic [7:0]           ctrl_q;
    logic [7:0]           devtype_q;
    logic [USP_IRQ_W-1:0] irq_stat_q;
    logic [USP_IRQ_W-1:0] irq_mask_q;
    logic [1:0]           latch_q;
    logic [1:0]           reserved_q;
    logic [1:0]           prio_dis_q;
    logic                 turn_q;
    logic [1:0]           match;
    logic [1:0]           allowed;
    logic [1:0]           grant;
    logic [1:0]           want;
    logic [1:0]           maint_dis;
    logic [1:0]           refused;
    logic [USP_IRQ_W-1:0] irq_event;

    assign maint_dis = {ctrl_q[USP_CTRL_DIS1], ctrl_q[USP_CTRL_DIS0]};

    genvar ch;
    generate
        for (ch = 0; ch < USP_CHANNELS; ch++) begin : g_chan
            // Address lines are assumed settled while the tag is high.
            assign match[ch] = i_unit_select_tag[ch]
                             && (i_unit_select_addr[ch*4 +: 4] == i_addr_switch)
                             && !i_cable_absent[ch]
                             && !maint_dis[ch]
                             && !prio_dis_q[ch];
            // The other side's reservation or selection blocks this one.
            assign allowed[ch] = !latch_q[1-ch] && !reserved_q[1-ch];
            assign refused[ch] = match[ch] && !allowed[ch];
            assign o_unit_selected[ch] = match[ch] && allowed[ch] && grant[ch];
            assign o_iface_enable[ch]  = latch_q[ch];

            usp_unit_mux u_mux (
                .i_mclk         (i_mclk),
                .i_rst_n        (i_rst_n),
                .i_enable       (latch_q[ch]),
                .i_selector     (i_bus_out_sel[ch*2 +: 2]),
                .i_tag4         (i_tag4[ch]),
                .i_tag5         (i_tag5[ch]),
                .i_op_status    (i_op_status),
                .i_status_valid (i_status_valid),
                .i_unit_code    (i_unit_code),
                .i_diag_running (i_diag_running),
                .i_device_type  (devtype_q),
                .o_bus_in       (o_bus_in[ch*8 +: 8])
            );
        end
    endgenerate

    // Simultaneous attempts are decided by an alternating turn bit, so neither side starves.
    // Only attempts that could succeed compete. A channel that already holds the drive
    // keeps its grant while the other side merely tries and gets refused.
    always_comb begin
        want  = match & (allowed | i_priority_select);
        grant = 2'h0;
        if (want[0] && want[1]) begin
            grant[turn_q] = 1'b1;
        end else begin
            grant = want;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            turn_q <= 1'b0;
        end else begin
            turn_q <= ~turn_q;
        end
    end

    // The connection latch follows the tag: it drops when the tag goes away.
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            latch_q <= 2'h0;
        end else begin
            for (int i = 0; i < USP_CHANNELS; i++) begin
                if (i_priority_select[i] && match[i] && grant[i]) begin
                    latch_q[i] <= 1'b1;
                end else if (i_priority_select[1-i] && match[1-i] && grant[1-i]) begin
                    latch_q[i] <= 1'b0;
                end else if (!match[i]) begin
                    latch_q[i] <= 1'b0;
                end else if (allowed[i] && grant[i]) begin
                    latch_q[i] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            reserved_q <= 2'h0;
        end else begin
            for (int i = 0; i < USP_CHANNELS; i++) begin
                if (i_priority_select[1-i] && match[1-i] && grant[1-i]) begin
                    reserved_q[i] <= 1'b0;
                end else if (latch_q[i] && i_release[i]) begin
                    reserved_q[i] <= 1'b0;
                end else if (latch_q[i]) begin
                    reserved_q[i] <= 1'b1;
                end
            end
        end
    end

    // A priority take-over shuts the losing channel until its disable is cleared by software.
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prio_dis_q <= 2'h0;
        end else begin
            for (int i = 0; i < USP_CHANNELS; i++) begin
                if (i_priority_select[1-i] && match[1-i] && grant[1-i]) begin
                    prio_dis_q[i] <= 1'b1;
                end else if (i_reg_wr && i_reg_addr == USP_REG_STATE && i_reg_wdata[4+i]) begin
                    prio_dis_q[i] <= 1'b0;
                end
            end
        end
    end

    assign irq_event[USP_IRQ_SEL0]    = latch_q[0] == 1'b0 && o_unit_selected[0];
    assign irq_event[USP_IRQ_SEL1]    = latch_q[1] == 1'b0 && o_unit_selected[1];
    assign irq_event[USP_IRQ_PRIO]    = |(i_priority_select & match & grant);
    assign irq_event[USP_IRQ_REFUSED] = |refused;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_q    <= USP_CTRL_RST;
            devtype_q <= USP_DEVTYPE_RST;
        end else if (i_reg_wr) begin
            if (i_reg_addr == USP_REG_CTRL) begin
                ctrl_q <= i_reg_wdata;
            end
            if (i_reg_addr == USP_REG_DEVTYPE) begin
                devtype_q <= i_reg_wdata;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            irq_mask_q <= USP_MASK_RST;
        end else if (i_reg_wr && i_reg_addr == USP_REG_IRQ_MASK) begin
            irq_mask_q <= i_reg_wdata[USP_IRQ_W-1:0];
        end
    end

    // Set wins over a write-one clear in the same cycle.
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            irq_stat_q <= '0;
        end else begin
            for (int i = 0; i < USP_IRQ_W; i++) begin
                if (irq_event[i]) begin
                    irq_stat_q[i] <= 1'b1;
                end else if (i_reg_wr && i_reg_addr == USP_REG_IRQ_STAT && i_reg_wdata[i]) begin
                    irq_stat_q[i] <= 1'b0;
                end
            end
        end
    end

    assign o_irq      = |(irq_stat_q & irq_mask_q);
    assign o_reserved = reserved_q;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            case (i_reg_addr)
                USP_REG_CTRL:     o_reg_rdata <= ctrl_q;
                USP_REG_STATE:    o_reg_rdata <= {2'h0, prio_dis_q, reserved_q, latch_q};
                USP_REG_IRQ_STAT: o_reg_rdata <= {4'h0, irq_stat_q};
                USP_REG_IRQ_MASK: o_reg_rdata <= {4'h0, irq_mask_q};
                USP_REG_DEVTYPE:  o_reg_rdata <= devtype_q;
                default:          o_reg_rdata <= 8'h00;
            endcase
        end else begin
            o_reg_rdata <= 8'h00;
        end
    end

endmodule : usp_select_port

// file: bench/usp_select_port_assertions.sv
`timescale 1ns/1ps
module usp_select_port_assertions
    import usp_pkg::*;
(
    input wire logic                            i_mclk,
    input wire logic                            i_rst_n,
    input wire logic [3:0]                      i_addr_switch,
    input wire logic [1:0]                      i_unit_select_tag,
    input wire logic [7:0]                      i_unit_select_addr,
    input wire logic [1:0]                      i_cable_absent,
    input wire logic [1:0]                      i_priority_select,
    input wire logic [3:0]                      i_bus_out_sel,
    input wire logic [1:0]                      i_tag4,
    input wire logic [1:0]                      i_tag5,
    input wire logic [usp_pkg::USP_STAT_W-1:0]  i_op_status,
    input wire logic                            i_status_valid,
    input wire logic [usp_pkg::USP_UNIT_W-1:0]  i_unit_code,
    input wire logic                            i_diag_running,
    input wire logic [1:0]                      o_unit_selected,
    input wire logic [1:0]                      o_iface_enable,
    input wire logic [1:0]                      o_reserved,
    input wire logic [15:0]                     o_bus_in
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    wire t45 = i_tag4[0] & i_tag5[0];
    wire live = o_iface_enable[0] & !t45;
    a_unsel_bus_quiet: assert property (!$past(o_iface_enable[0]) |-> o_bus_in[7:0] == 8'h00)
        else $error("bus driven while unlatched");
    a_match_needed: assert property (o_unit_selected[0] |-> i_unit_select_tag[0] && !i_cable_absent[0]
        && i_unit_select_addr[3:0] == i_addr_switch) else $error("selected without a match");
    a_select_latches: assert property (o_unit_selected[0] |=> o_iface_enable[0])
        else $error("latch not set");
    a_latch_drops: assert property (o_iface_enable[0] && !i_unit_select_tag[0] |=> !o_iface_enable[0])
        else $error("latch held without tag");
    a_one_channel: assert property (!(o_iface_enable[0] && o_iface_enable[1]))
        else $error("both channels latched");
    a_status_mode: assert property ($past(live) && $past(i_bus_out_sel[1:0]) == USP_SEL_STATUS
        |-> o_bus_in[7:0] == {$past(i_status_valid), $past(i_op_status)}) else $error("status byte wrong");
    a_unit_mode: assert property ($past(live) && $past(i_bus_out_sel[1:0]) == USP_SEL_UNIT
        |-> o_bus_in[7:0] == {$past(i_status_valid), 3'h0, $past(i_unit_code)}) else $error("unit byte wrong");
    a_diag_mode: assert property ($past(live) && $past(i_bus_out_sel[1:0]) == USP_SEL_DIAG
        |-> o_bus_in[7] == $past(i_diag_running)) else $error("diag bit wrong");
    a_reserve_refuse: assert property (o_reserved[1] && !i_priority_select[0] |-> !o_unit_selected[0])
        else $error("reserved channel taken");
endmodule : usp_select_port_assertions

bind usp_select_port usp_select_port_assertions usp_select_port_assertions_i (.i_mclk, .i_rst_n, .i_addr_switch,
    .i_unit_select_tag, .i_unit_select_addr, .i_cable_absent, .i_priority_select, .i_bus_out_sel, .i_tag4,
    .i_tag5, .i_op_status, .i_status_valid, .i_unit_code, .i_diag_running, .o_unit_selected, .o_iface_enable,
    .o_reserved, .o_bus_in);

// file: bench/usp_ctrl_model.sv
`timescale 1ns/1ps
// One controller channel; idle address lines toggle so a stale address never looks valid.
module usp_ctrl_model (
    input  wire logic       i_mclk,
    input  wire logic       i_rst_n,
    input  wire logic       i_req,
    input  wire logic [3:0] i_addr,
    output logic            o_tag,
    output logic      [3:0] o_addr
);
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_tag <= 1'b0;
            o_addr <= 4'h0;
        end else begin
            o_tag <= i_req;
            if (!i_req) o_addr <= ~o_addr;
            else if (!o_tag) o_addr <= i_addr;
        end
    end
endmodule : usp_ctrl_model

// file: bench/test_unit_select_and_status_port.sv
`timescale 1ns/1ps
module test_unit_select_and_status_port;
    import usp_pkg::*;
    logic        i_mclk, i_rst_n, val, dg, wr, rd, irq, hit;
    logic [1:0]  req, tag, cab, rel, pri, t4, t5, usel, en, rsv;
    logic [3:0]  sw, bos, rad, uc;
    logic [6:0]  op;
    logic [7:0]  ai, ao, wd, rdata, rv, devt;
    logic [15:0] bin;
    logic [31:0] n;
    int          errors, num_checks, seed;

    usp_ctrl_model usp_ctrl_model_i[1:0] (.i_mclk, .i_rst_n, .i_req(req), .i_addr(ai), .o_tag(tag), .o_addr(ao));
    usp_select_port usp_select_port_i (.i_mclk, .i_rst_n, .i_addr_switch(sw), .i_unit_select_tag(tag),
        .i_unit_select_addr(ao), .i_cable_absent(cab), .i_release(rel), .i_priority_select(pri),
        .i_bus_out_sel(bos), .i_tag4(t4), .i_tag5(t5), .i_op_status(op), .i_status_valid(val),
        .i_unit_code(uc), .i_diag_running(dg), .i_reg_addr(rad), .i_reg_wdata(wd), .i_reg_wr(wr),
        .i_reg_rd(rd), .o_reg_rdata(rdata), .o_unit_selected(usel), .o_iface_enable(en), .o_reserved(rsv),
        .o_bus_in(bin), .o_irq(irq));

    initial begin
        i_mclk = 1'b0;
        forever #2 i_mclk = ~i_mclk;
    end

    task automatic print_verdict;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : print_verdict

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int k);
        repeat (k) @(posedge i_mclk);
        #1;
    endtask : tick

    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        rad <= a;
        wd <= d;
        wr <= 1'b1;
        tick(1);
        wr <= 1'b0;
    endtask : wreg

    task automatic rreg(input logic [3:0] a);
        @(posedge i_mclk);
        rad <= a;
        rd <= 1'b1;
        tick(1);
        rd <= 1'b0;
        rv = rdata;
    endtask : rreg

    function automatic logic [7:0] exp_bus(input logic [1:0] s, input logic t);
        if (t) return devt;
        case (s)
            USP_SEL_STATUS: return {val, op};
            USP_SEL_UNIT:   return {val, 3'h0, uc};
            USP_SEL_DIAG:   return {dg, 7'h00};
            default:        return 8'h00;
        endcase
    endfunction : exp_bus

    task automatic drive_sel(input logic [1:0] s, input logic t);
        @(posedge i_mclk);
        bos[1:0] <= s;
        t4[0] <= t;
        t5[0] <= t;
        {op, val, uc, dg} <= 13'($random(seed));
        tick(1);
        check(bin[7:0], exp_bus(s, t));
    endtask : drive_sel

    initial begin
        #100000;
        errors++;
        print_verdict;
    end

    initial begin
        seed = 32'hD05B;
        i_rst_n = 1'b0;
        {sw, ai, req, cab, rel, pri, t4, t5, bos, rad, wd, wr, rd} = '0;
        {op, val, uc, dg} = '0;
        repeat (10) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        // Reset values, including the unmapped hole, all read zero.
        for (int k = 0; k < 6; k++) begin
            rreg(k == 5 ? 4'hF : 4'(k));
            check(rv, 8'h00);
        end
        devt = 8'($random(seed));
        wreg(USP_REG_DEVTYPE, devt);
        for (int i = 0; i < 12; i++) begin
            n = $random(seed);
            @(posedge i_mclk);
            sw <= n[3:0];
            ai[3:0] <= (i < 2 || n[4]) ? n[3:0] : n[7:4];
            cab[0] <= i > 1 && n[5] && n[6];
            req[0] <= 1'b1;
            tick(3);
            hit = ai[3:0] == sw && !cab[0];
            check(usel[0], hit);
            check(en[0], hit);
            if (hit) for (int k = 0; k < 5; k++) drive_sel(2'(k), k == 4);
            else check(bin[7:0], 8'h00);
            @(posedge i_mclk);
            req[0] <= 1'b0;
            t4 <= 2'b00;
            t5 <= 2'b00;
            cab <= 2'b00;
            tick(3);
            check(en[0], 1'b0);
        end
        check(rsv, 2'b01);
        @(posedge i_mclk);
        ai[7:4] <= sw;
        req[1] <= 1'b1;
        tick(3);
        check({usel[1], en[1]}, 2'b00);
        @(posedge i_mclk);
        req[1] <= 1'b0;
        rreg(USP_REG_IRQ_STAT);
        check(rv, 8'h09);
        check(irq, 1'b0);
        wreg(USP_REG_IRQ_MASK, 8'h04);
        check(irq, 1'b0);
        wreg(USP_REG_IRQ_MASK, 8'h08);
        check(irq, 1'b1);
        wreg(USP_REG_IRQ_STAT, 8'hFF);
        rreg(USP_REG_IRQ_STAT);
        check({irq, rv}, 9'h000);
        @(posedge i_mclk);
        req[1] <= 1'b1;
        pri[1] <= 1'b1;
        tick(3);
        check({en, rsv}, 4'hA);
        rreg(USP_REG_STATE);
        check(rv, 8'h1A);
        @(posedge i_mclk);
        bos[3:2] <= USP_SEL_UNIT;
        tick(1);
        check(bin, {val, 3'h0, uc, 8'h00});
        @(posedge i_mclk);
        pri[1] <= 1'b0;
        rel[1] <= 1'b1;
        tick(2);
        check(rsv, 2'b00);
        // Release stays up until the latch has dropped, or the reserve would come back.
        @(posedge i_mclk);
        req[1] <= 1'b0;
        tick(3);
        check({en, rsv}, 4'h0);
        @(posedge i_mclk);
        rel[1] <= 1'b0;
        wreg(USP_REG_STATE, 8'h10);
        wreg(USP_REG_CTRL, 8'h01);
        @(posedge i_mclk);
        ai[3:0] <= sw;
        req[0] <= 1'b1;
        tick(3);
        check({usel[0], en[0]}, 2'b00);
        wreg(USP_REG_CTRL, 8'h00);
        tick(2);
        check(en[0], 1'b1);
        print_verdict;
    end
endmodule : test_unit_select_and_status_port
